// ---- hdl/bswv_pkg.sv ----
package bswv_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ          = 200;
  localparam int unsigned SLEEP_TIMEOUT_US   = 100;   // Sleep entry timeout, microseconds
  localparam int unsigned WAKE_DELAY_US      = 1;     // Wake delay, microseconds
  // Sleep entry is a least time: round up
  localparam int unsigned SLEEP_TIMEOUT_CYC  = (SLEEP_TIMEOUT_US * CLOCK_MHZ);
  // Wake delay is a longest time: round down, at least one
  localparam int unsigned WAKE_DELAY_CYC_RAW = (WAKE_DELAY_US * CLOCK_MHZ);
  localparam int unsigned WAKE_DELAY_CYC     = (WAKE_DELAY_CYC_RAW < 1) ? 1 : WAKE_DELAY_CYC_RAW;
  localparam int unsigned WAKE_CNT_W         = 8;
  localparam int unsigned SLEEP_CNT_W        = 16;

  // ----------------------------------------------------------------
  // Reset values and threshold modes
  // ----------------------------------------------------------------
  localparam logic [2:0] GATE_RESET = 3'h0;
  localparam logic       FAULT_RESET = 1'h0;

  typedef enum logic [2:0] {
    BSWV_THR_OFF      = 3'h1,   // Below disable level
    BSWV_THR_EXTERNAL = 3'h2,   // Analog window, follow pin
    BSWV_THR_INTERNAL = 3'h4    // Above pull-up level
  } bswv_thr_e;

  typedef enum logic [2:0] {
    BSWV_RUN   = 3'h1,
    BSWV_SLEEP = 3'h2,
    BSWV_WAKE  = 3'h4
  } bswv_state_e;

endpackage

// ---- hdl/bswv_sleep_wake.sv ----
`timescale 1ns/100ps
// Behaviour
// - All six commands low for the full timeout puts the device asleep.
// - Asleep, every gate output and the fault output float.
// - Any command high wakes the device within the wake delay.
// - Sleep exists only without regulator; otherwise all-low changes nothing.
// - High gate output high turns the high MOSFET on, low turns off.
// - Threshold input below disable level suppresses drain fault reporting.
// - Threshold input above pull-up level selects the internal drain threshold.
// - Threshold input in analog window makes the threshold track that voltage.
// - Both commands high on a phase drive both gates low.
// - Drain fault while a gate is on raises fault, gates unaffected.
module bswv_sleep_wake #(
  parameter int unsigned SLEEP_CYCLES = bswv_pkg::SLEEP_TIMEOUT_CYC  // Sleep entry count
) (
  input  wire logic       clock,              // 200 MHz clock
  input  wire logic       rst_n,              // Async reset, active low
  input  wire logic       hasRegulator,       // Strap: regulator variant, no sleep
  input  wire logic [2:0] highSideCmd,        // High-side commands, phases A..C
  input  wire logic [2:0] lowSideCmd,         // Low-side commands, phases A..C
  input  wire logic       levelBelowDisable,  // Threshold input under disable level
  input  wire logic       levelAbovePullup,   // Threshold input over pull-up level
  input  wire logic [5:0] drainOverExternal,  // Drain voltage above applied level
  input  wire logic [5:0] drainOverInternal,  // Drain voltage above internal level
  output logic      [2:0] highGateOut,        // High-side gate drive
  output logic      [2:0] highGateOe,         // High-side gate driven, else float
  output logic      [2:0] lowGateOut,         // Low-side gate drive
  output logic      [2:0] lowGateOe,          // Low-side gate driven, else float
  output logic            faultOut,           // Fault, active high
  output logic            faultOe,            // Fault driven, else float
  output logic            asleep              // Device in sleep
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bswv_pkg::bswv_state_e                   state_reg;
  bswv_pkg::bswv_state_e                   state_next;
  bswv_pkg::bswv_thr_e                     thrMode;
  logic [bswv_pkg::SLEEP_CNT_W-1:0]        sleepCnt_reg;
  logic [bswv_pkg::WAKE_CNT_W-1:0]         wakeCnt_reg;
  logic                                    anyHigh;
  logic                                    sleepDone;
  logic [2:0]                              highNext;
  logic [2:0]                              lowNext;
  logic [5:0]                              gateOn;
  logic [5:0]                              drainOver;
  logic                                    faultNext;

  // Lock-out: a phase with both commands high drives both gates low
  function automatic logic [2:0] lockHigh(input logic [2:0] hi, input logic [2:0] lo);
    lockHigh = hi & ~lo;
  endfunction

  assign anyHigh   = |{highSideCmd, lowSideCmd};
  assign sleepDone = (sleepCnt_reg == SLEEP_CYCLES[bswv_pkg::SLEEP_CNT_W-1:0] - 16'h0001);

  // ----------------------------------------------------------------
  // Sleep timer
  // ----------------------------------------------------------------
  // Restarts on any high so only an unbroken all-low interval counts
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sleepCnt_reg <= 16'h0000;
    end else if (anyHigh || hasRegulator || state_reg != bswv_pkg::BSWV_RUN) begin
      sleepCnt_reg <= 16'h0000;
    end else if (!sleepDone) begin
      sleepCnt_reg <= sleepCnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------
  // Wake passes through a short settle; the regulator strap forces run
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bswv_pkg::BSWV_RUN: begin
        if (sleepDone && !anyHigh && !hasRegulator) begin
          state_next = bswv_pkg::BSWV_SLEEP;
        end
      end
      bswv_pkg::BSWV_SLEEP: begin
        if (anyHigh || hasRegulator) begin
          state_next = bswv_pkg::BSWV_WAKE;
        end
      end
      bswv_pkg::BSWV_WAKE: begin
        if (wakeCnt_reg == 8'h00) begin
          state_next = bswv_pkg::BSWV_RUN;
        end
      end
      default: state_next = bswv_pkg::BSWV_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bswv_pkg::BSWV_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Wake counter: kept well under the wake delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wakeCnt_reg <= 8'h00;
    end else if (state_reg == bswv_pkg::BSWV_SLEEP) begin
      wakeCnt_reg <= 8'h01;
    end else if (wakeCnt_reg != 8'h00) begin
      wakeCnt_reg <= wakeCnt_reg - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Gate drive
  // ----------------------------------------------------------------
  assign highNext = lockHigh(highSideCmd, lowSideCmd);
  assign lowNext  = lockHigh(lowSideCmd, highSideCmd);

  // Gates held low during wake settle; floated while asleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      highGateOut <= bswv_pkg::GATE_RESET;
      lowGateOut  <= bswv_pkg::GATE_RESET;
      highGateOe  <= 3'h7;
      lowGateOe   <= 3'h7;
      asleep      <= 1'b0;
    end else begin
      highGateOut <= (state_next == bswv_pkg::BSWV_RUN) ? highNext : 3'h0;
      lowGateOut  <= (state_next == bswv_pkg::BSWV_RUN) ? lowNext : 3'h0;
      highGateOe  <= (state_next == bswv_pkg::BSWV_SLEEP) ? 3'h0 : 3'h7;
      lowGateOe   <= (state_next == bswv_pkg::BSWV_SLEEP) ? 3'h0 : 3'h7;
      asleep      <= (state_next == bswv_pkg::BSWV_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Drain monitor
  // ----------------------------------------------------------------
  always_comb begin
    if (levelBelowDisable) begin
      thrMode = bswv_pkg::BSWV_THR_OFF;
    end else if (levelAbovePullup) begin
      thrMode = bswv_pkg::BSWV_THR_INTERNAL;
    end else begin
      thrMode = bswv_pkg::BSWV_THR_EXTERNAL;
    end
  end

  // Comparators are analog; only the selection lives here
  assign gateOn    = {highGateOut, lowGateOut};
  assign drainOver = (thrMode == bswv_pkg::BSWV_THR_INTERNAL) ? drainOverInternal
                                                             : drainOverExternal;
  assign faultNext = (thrMode != bswv_pkg::BSWV_THR_OFF) && |(gateOn & drainOver);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      faultOut <= bswv_pkg::FAULT_RESET;
      faultOe  <= 1'b1;
    end else begin
      faultOut <= faultNext;
      faultOe  <= (state_next != bswv_pkg::BSWV_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sleep_entry: assert property (@(posedge clock) disable iff (!rst_n)
    sleepDone && !anyHigh && !hasRegulator && state_reg == bswv_pkg::BSWV_RUN
      |=> asleep)
    else $error("sleep not entered after timeout");

  chk_sleep_float: assert property (@(posedge clock) disable iff (!rst_n)
    asleep |-> (highGateOe == 3'h0 && lowGateOe == 3'h0 && !faultOe))
    else $error("outputs driven while asleep");

  chk_wake_bound: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == bswv_pkg::BSWV_SLEEP && anyHigh) |-> ##[1:3] !asleep && highGateOe == 3'h7)
    else $error("wake too slow");

  chk_regulator_nosleep: assert property (@(posedge clock) disable iff (!rst_n)
    hasRegulator && $past(hasRegulator) |=> !asleep)
    else $error("sleep on regulator variant");

  chk_high_drive: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == bswv_pkg::BSWV_RUN && state_next == bswv_pkg::BSWV_RUN)
      |=> highGateOut == $past(highNext))
    else $error("high gate not following command");

  chk_drain_off: assert property (@(posedge clock) disable iff (!rst_n)
    levelBelowDisable |=> !faultOut)
    else $error("drain fault while disabled");

  chk_internal_thr: assert property (@(posedge clock) disable iff (!rst_n)
    (levelAbovePullup && !levelBelowDisable && |(gateOn & drainOverInternal)) |=> faultOut)
    else $error("internal threshold ignored");

  chk_external_thr: assert property (@(posedge clock) disable iff (!rst_n)
    (!levelAbovePullup && !levelBelowDisable && (gateOn & drainOverExternal) == 6'h00)
      |=> !faultOut)
    else $error("fault without external threshold crossing");

  chk_phase_lockout: assert property (@(posedge clock) disable iff (!rst_n)
    (highGateOut & lowGateOut) == 3'h0)
    else $error("both gates of a phase on");

  chk_fault_keeps_gates: assert property (@(posedge clock) disable iff (!rst_n)
    (faultOut && state_reg == bswv_pkg::BSWV_RUN && state_next == bswv_pkg::BSWV_RUN)
      |=> highGateOut == $past(highNext))
    else $error("fault disabled a gate");

  chk_timer_restart: assert property (@(posedge clock) disable iff (!rst_n)
    anyHigh |=> sleepCnt_reg == 16'h0000)
    else $error("sleep timer not restarted");

endmodule

// ---- sim/bswv_mcu_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Controller model
// ----------------------------------------------------------------
module bswv_mcu_model (
  input  wire logic       clock,        // Device clock
  output logic      [2:0] highSideCmd,  // High-side commands
  output logic      [2:0] lowSideCmd    // Low-side commands
);
  logic [2:0] charged;  // Bootstrap charged, per phase

  // Idle low from time zero
  initial begin
    highSideCmd <= 3'h0;
    lowSideCmd  <= 3'h0;
    charged     = 3'h0;
  end

  // Uncharged phases get a low-side pulse first, else the high side starves
  task automatic command(input logic [2:0] hi, input logic [2:0] lo);
    if ((hi & ~charged) != 3'h0) begin
      @(posedge clock);
      highSideCmd <= 3'h0;
      lowSideCmd  <= hi & ~charged;
      charged = charged | hi;
    end
    @(posedge clock);
    highSideCmd <= hi;
    lowSideCmd  <= lo;
    charged = charged | lo;
  endtask

  // Wake with every low side at once so all bootstraps recharge
  task automatic wake();
    @(posedge clock);
    highSideCmd <= 3'h0;
    lowSideCmd  <= 3'h7;
    charged = 3'h7;
  endtask

  // All low; the bootstraps are assumed to drain in sleep
  task automatic release_all();
    @(posedge clock);
    highSideCmd <= 3'h0;
    lowSideCmd  <= 3'h0;
    charged = 3'h0;
  endtask
endmodule

// ---- sim/bswv_sleep_wake_test.sv ----
`timescale 1ns/100ps
module bswv_sleep_wake_test;
  localparam int unsigned SLEEP_CYC = 8;  // Short timeout keeps the run brief
  logic       clock, rst_n, hasRegulator, levelBelowDisable, levelAbovePullup;
  logic [5:0] drainOverExternal, drainOverInternal;
  logic [2:0] highSideCmd, lowSideCmd, highGateOut, highGateOe, lowGateOut, lowGateOe;
  logic       faultOut, faultOe, asleep;
  int         failures, samples_checked;

  // Clock at 5 ns
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  bswv_mcu_model mcu (.clock(clock), .highSideCmd(highSideCmd), .lowSideCmd(lowSideCmd));

  bswv_sleep_wake #(.SLEEP_CYCLES(SLEEP_CYC)) dut (
    .clock(clock), .rst_n(rst_n), .hasRegulator(hasRegulator),
    .highSideCmd(highSideCmd), .lowSideCmd(lowSideCmd),
    .levelBelowDisable(levelBelowDisable), .levelAbovePullup(levelAbovePullup),
    .drainOverExternal(drainOverExternal), .drainOverInternal(drainOverInternal),
    .highGateOut(highGateOut), .highGateOe(highGateOe), .lowGateOut(lowGateOut),
    .lowGateOe(lowGateOe), .faultOut(faultOut), .faultOe(faultOe), .asleep(asleep));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Sample a little after the edge so its updates have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic close_out();
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_lockout();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      mcu.command({3{c[1]}}, {3{c[0]}});
      settle(1);
      check("highGateOut", {5'h0, highGateOut}, {5'h0, {3{c[1] & ~c[0]}}});
      check("lowGateOut", {5'h0, lowGateOut}, {5'h0, {3{c[0] & ~c[1]}}});
    end
  endtask

  // A blip just before the timeout must restart the count
  task automatic test_sleep();
    int n;
    n = 0;
    mcu.release_all();
    settle(SLEEP_CYC - 2);
    mcu.command(3'h0, 3'h1);
    mcu.release_all();
    settle(SLEEP_CYC - 2);
    check("asleep early", {7'h0, asleep}, 8'h00);
    while (asleep !== 1'b1 && n < 2 * SLEEP_CYC) begin
      settle(1);
      n++;
    end
    check("asleep", {7'h0, asleep}, 8'h01);
    check("oe asleep", {1'b0, highGateOe, lowGateOe, faultOe}, 8'h00);
  endtask

  task automatic test_wake();
    mcu.wake();
    settle(3);
    check("asleep woken", {7'h0, asleep}, 8'h00);
    check("oe awake", {1'b0, highGateOe, lowGateOe, faultOe}, 8'h7f);
    settle(2);
    check("lowGateOut woken", {5'h0, lowGateOut}, 8'h07);
  endtask

  task automatic test_regulator();
    @(posedge clock);
    hasRegulator <= 1'b1;
    mcu.release_all();
    settle(3 * SLEEP_CYC);
    check("asleep regulator", {7'h0, asleep}, 8'h00);
    check("oe regulator", {1'b0, highGateOe, lowGateOe, faultOe}, 8'h7f);
    @(posedge clock);
    hasRegulator <= 1'b0;
    mcu.wake();
    settle(5);
  endtask

  // Every threshold mode against both comparators; low sides stay on
  task automatic test_fault();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      @(posedge clock);
      levelBelowDisable <= m[2];
      levelAbovePullup  <= m[1];
      drainOverExternal <= {5'h0, ~m[0]};
      drainOverInternal <= {5'h0, m[0]};
      settle(2);
      check("faultOut", {7'h0, faultOut}, {7'h0, ~m[2] & (m[1] ? m[0] : ~m[0])});
      check("lowGateOut fault", {5'h0, lowGateOut}, 8'h07);
    end
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_n             <= 1'b0;
    hasRegulator      <= 1'b0;
    levelBelowDisable <= 1'b0;
    levelAbovePullup  <= 1'b0;
    drainOverExternal <= 6'h00;
    drainOverInternal <= 6'h00;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    test_lockout();
    test_sleep();
    test_wake();
    test_regulator();
    test_fault();
    close_out();
  end
endmodule
